// *** fmd_pkg.sv ***
// Constants and types for the per-port framer mode decoder.
// Assumes one system clock and an asynchronous active-low global reset.
`default_nettype none
package fmd_pkg;
    localparam int NUM_PORTS = 4;
    localparam int MODE_W = 6;
    localparam int LINE_W = 3;
    // Framer mode bit positions.
    localparam int MODE_TOP = 5;
    localparam int MODE_B2 = 2;
    localparam int MODE_B1 = 1;
    localparam int MODE_B0 = 0;
    localparam logic [5:0] MODE_E3_G751_MASK = 6'h15;
    localparam logic [5:0] MODE_RESET = 6'h00;
    localparam logic [1:0] BUS_RESET = 2'h0;
    localparam logic [2:0] LINE_RESET = 3'h0;
    localparam logic [2:0] LINE_UNIPOLAR = 3'h4;
    localparam logic [1:0] BUS_UTOPIA_L2 = 2'h0;
    localparam logic [1:0] BUS_UTOPIA_L3 = 2'h1;
    localparam logic [1:0] BUS_PKT_L2 = 2'h2;
    localparam logic [1:0] BUS_PKT_L3 = 2'h3;
    typedef enum logic [7:0] {
        FMD_NONE = 8'h01,
        FMD_INT_SUB = 8'h02,
        FMD_EXT_SUB = 8'h04,
        FMD_FLEX_SUB = 8'h08,
        FMD_PLCP = 8'h10,
        FMD_PLCPM = 8'h20,
        FMD_CLR = 8'h40,
        FMD_CLRM = 8'h80
    } fmd_mode_e;
endpackage
`default_nettype wire

// *** fmd_port.sv ***
// One port's mode decode: registered mapping enables from its own settings.
// Assumes settings are synchronous to clk and shared interface select.
`default_nettype none
module fmd_port (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Configuration
    input wire logic [5:0] framer_mode_field,
    input wire logic cell_packet_select,
    input wire logic [1:0] system_interface_select,
    input wire logic e3_line,
    // Decoded enables
    output logic [7:0] mode_onehot,
    output logic atm_cells,
    output logic force_unipolar,
    output logic framer_enable,
    output logic line_unit_enable,
    output logic datapath_reset,
    output logic config_error
);
    fmd_pkg::fmd_mode_e mode;
    fmd_pkg::fmd_mode_e next_mode;
    logic next_atm;
    logic next_err;
    logic atm_reg;
    logic err_reg;

    function automatic fmd_pkg::fmd_mode_e decode(input logic [5:0] code);
        logic [2:0] lo;
        lo = code[fmd_pkg::MODE_B2:fmd_pkg::MODE_B0];
        if (!code[fmd_pkg::MODE_TOP])
        begin
            case (lo)
                3'h2: decode = fmd_pkg::FMD_INT_SUB;
                3'h3: decode = fmd_pkg::FMD_EXT_SUB;
                3'h6: decode = fmd_pkg::FMD_FLEX_SUB;
                3'h4: decode = fmd_pkg::FMD_PLCP;
                3'h5: decode = fmd_pkg::FMD_PLCPM;
                default: decode = fmd_pkg::FMD_NONE;
            endcase
        end
        else if (!code[fmd_pkg::MODE_B2] && !code[fmd_pkg::MODE_B0])
            decode = fmd_pkg::FMD_CLR;
        else if (!code[fmd_pkg::MODE_B2] && !code[fmd_pkg::MODE_B1])
            decode = fmd_pkg::FMD_CLRM;
        else
            decode = fmd_pkg::FMD_NONE;
    endfunction

    always_comb
    begin
        next_mode = decode(framer_mode_field);
        next_err = 1'b0;
        // E3 overhead-mask PLCP only with the one legal code; else held off.
        if (next_mode == fmd_pkg::FMD_PLCPM && e3_line
            && framer_mode_field != fmd_pkg::MODE_E3_G751_MASK)
        begin
            next_mode = fmd_pkg::FMD_NONE;
            next_err = 1'b1;
        end
        case (next_mode)
            fmd_pkg::FMD_PLCP, fmd_pkg::FMD_PLCPM: next_atm = 1'b1;
            default:
                next_atm = (system_interface_select == fmd_pkg::BUS_PKT_L2
                    || system_interface_select == fmd_pkg::BUS_PKT_L3)
                    ? cell_packet_select : 1'b1;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mode <= fmd_pkg::FMD_NONE;
            atm_reg <= 1'b1;
            err_reg <= 1'b0;
        end
        else
        begin
            mode <= next_mode;
            atm_reg <= next_atm;
            err_reg <= next_err;
        end
    end

    assign mode_onehot = mode;
    assign atm_cells = atm_reg;
    assign config_error = err_reg;
    assign force_unipolar = (mode == fmd_pkg::FMD_PLCPM) || (mode == fmd_pkg::FMD_CLRM);
    // Clear-channel modes bypass the framer; the datapath sits in reset only in the no-mode state.
    assign framer_enable = !(mode == fmd_pkg::FMD_NONE || mode == fmd_pkg::FMD_CLR
        || mode == fmd_pkg::FMD_CLRM);
    assign line_unit_enable = !(mode == fmd_pkg::FMD_NONE || force_unipolar);
    assign datapath_reset = (mode == fmd_pkg::FMD_NONE);

    chk_unlisted_reset: assert property (@(posedge clk) disable iff (!arst_n)
        $past(decode(framer_mode_field)) == fmd_pkg::FMD_NONE |-> datapath_reset)
        else $error("unlisted mode code did not hold datapath in reset");
    chk_plcp_cells: assert property (@(posedge clk) disable iff (!arst_n)
        (mode == fmd_pkg::FMD_PLCP || mode == fmd_pkg::FMD_PLCPM) |-> atm_cells)
        else $error("PLCP mode without cell processing");
    chk_mask_unipolar: assert property (@(posedge clk) disable iff (!arst_n)
        mode == fmd_pkg::FMD_CLRM |-> force_unipolar && !line_unit_enable && !framer_enable)
        else $error("clear-channel mask mode not bypassing line path");
    // The first edge after reset still holds the reset mode whatever code stood before it,
    // so the decode checks only look at codes taken while out of reset.
    chk_clr_bypass: assert property (@(posedge clk) disable iff (!arst_n)
        $past(arst_n) && $past(framer_mode_field[5]) && !$past(framer_mode_field[2])
        && !$past(framer_mode_field[0]) |-> mode == fmd_pkg::FMD_CLR && !framer_enable)
        else $error("clear-channel code not decoded");
    chk_int_sub: assert property (@(posedge clk) disable iff (!arst_n)
        $past(arst_n) && !$past(framer_mode_field[5]) && $past(framer_mode_field[2:0]) == 3'h2
        |-> mode == fmd_pkg::FMD_INT_SUB && framer_enable)
        else $error("internal fractional code not decoded");
    chk_ext_sub: assert property (@(posedge clk) disable iff (!arst_n)
        $past(arst_n) && !$past(framer_mode_field[5]) && $past(framer_mode_field[2:0]) == 3'h3
        |-> mode == fmd_pkg::FMD_EXT_SUB)
        else $error("external fractional code not decoded");
    chk_flex_sub: assert property (@(posedge clk) disable iff (!arst_n)
        $past(arst_n) && !$past(framer_mode_field[5]) && $past(framer_mode_field[2:0]) == 3'h6
        |-> mode == fmd_pkg::FMD_FLEX_SUB)
        else $error("flexible fractional code not decoded");
    chk_plcp_sel: assert property (@(posedge clk) disable iff (!arst_n)
        $past(arst_n) && !$past(framer_mode_field[5]) && $past(framer_mode_field[2:0]) == 3'h4
        |-> mode == fmd_pkg::FMD_PLCP && !force_unipolar)
        else $error("PLCP code not decoded");
    chk_e3_mask: assert property (@(posedge clk) disable iff (!arst_n)
        mode == fmd_pkg::FMD_PLCPM && $past(e3_line)
        |-> $past(framer_mode_field) == fmd_pkg::MODE_E3_G751_MASK && force_unipolar)
        else $error("E3 mask PLCP with illegal code");
    chk_utopia_atm: assert property (@(posedge clk) disable iff (!arst_n)
        !$past(system_interface_select[1]) |-> atm_cells)
        else $error("UTOPIA bus not forced to cells");
endmodule
`default_nettype wire

// *** fmd_decoder.sv ***
// Top of the framer mode decoder: one independent decode per port.
// Assumes configuration inputs come from registers in the system clock domain.
`default_nettype none
module fmd_decoder (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Global configuration
    input wire logic [1:0] system_interface_select,
    // Per-port configuration
    input wire logic [23:0] framer_mode_field,
    input wire logic [3:0] cell_packet_select,
    input wire logic [3:0] e3_line,
    input wire logic [11:0] line_mode_field,
    // Bus type decode
    output logic utopia_l2,
    output logic utopia_l3,
    output logic pkt_l2,
    output logic pkt_l3,
    // Per-port decoded enables
    output logic [31:0] mode_onehot,
    output logic [3:0] atm_cells,
    output logic [3:0] framer_enable,
    output logic [3:0] line_unit_enable,
    output logic [3:0] datapath_reset,
    output logic [3:0] config_error,
    output logic [11:0] effective_line_mode
);
    logic [1:0] bus_sel;
    logic [1:0] next_bus_sel;
    logic [3:0] unipolar;

    always_comb
    begin
        next_bus_sel = system_interface_select;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            bus_sel <= fmd_pkg::BUS_RESET;
        else
            bus_sel <= next_bus_sel;
    end

    assign utopia_l2 = (bus_sel == fmd_pkg::BUS_UTOPIA_L2);
    assign utopia_l3 = (bus_sel == fmd_pkg::BUS_UTOPIA_L3);
    assign pkt_l2 = (bus_sel == fmd_pkg::BUS_PKT_L2);
    assign pkt_l3 = (bus_sel == fmd_pkg::BUS_PKT_L3);

    // Each port keeps its own settings; only the bus type is shared.
    for (genvar p = 0; p < fmd_pkg::NUM_PORTS; p++)
    begin : g_port
        logic [2:0] line_q;
        always_ff @(posedge clk or negedge arst_n)
        begin
            if (!arst_n)
                line_q <= fmd_pkg::LINE_RESET;
            else
                line_q <= line_mode_field[p*3 +: 3];
        end
        fmd_port u_port (
            .clk(clk),
            .arst_n(arst_n),
            .framer_mode_field(framer_mode_field[p*6 +: 6]),
            .cell_packet_select(cell_packet_select[p]),
            .system_interface_select(system_interface_select),
            .e3_line(e3_line[p]),
            .mode_onehot(mode_onehot[p*8 +: 8]),
            .atm_cells(atm_cells[p]),
            .force_unipolar(unipolar[p]),
            .framer_enable(framer_enable[p]),
            .line_unit_enable(line_unit_enable[p]),
            .datapath_reset(datapath_reset[p]),
            .config_error(config_error[p])
        );
        assign effective_line_mode[p*3 +: 3] = unipolar[p] ? fmd_pkg::LINE_UNIPOLAR : line_q;
    end
endmodule
`default_nettype wire

// *** fmd_decoder_tb.sv ***
// Self-checking bench for the framer mode decoder top, driving every port directly.
// Assumes the package and design files are compiled first and one 50 MHz clock.
`default_nettype none
`define CHK(got, exp, msg) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("mismatch t=%0t %s", $time, msg); \
        end \
    end
module fmd_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk;
    logic arst_n;
    logic [1:0] bus_sel;
    logic [23:0] mode_code;
    logic [3:0] cps;
    logic [3:0] e3;
    logic [11:0] line_code;
    logic utopia_l2, utopia_l3, pkt_l2, pkt_l3;
    logic [31:0] mode_onehot;
    logic [3:0] atm_cells, framer_enable, line_unit_enable, datapath_reset, config_error;
    logic [11:0] effective_line_mode;
    int n_mismatch = 0;
    int tests_run = 0;
    int seed_ret;

    fmd_decoder dut_u (.clk(clk), .arst_n(arst_n), .system_interface_select(bus_sel),
        .framer_mode_field(mode_code), .cell_packet_select(cps), .e3_line(e3),
        .line_mode_field(line_code),
        .utopia_l2(utopia_l2), .utopia_l3(utopia_l3), .pkt_l2(pkt_l2), .pkt_l3(pkt_l3),
        .mode_onehot(mode_onehot), .atm_cells(atm_cells), .framer_enable(framer_enable),
        .line_unit_enable(line_unit_enable), .datapath_reset(datapath_reset),
        .config_error(config_error), .effective_line_mode(effective_line_mode));

    // Expected one-hot mode of one port; the middle two bits take part only in the E3 mask code compare.
    function automatic logic [7:0] exp_mode(input logic [5:0] c, input logic e3v);
        if (!c[5])
        begin
            case (c[2:0])
                3'h2: return 8'h02;
                3'h3: return 8'h04;
                3'h6: return 8'h08;
                3'h4: return 8'h10;
                3'h5: return (e3v && c != fmd_pkg::MODE_E3_G751_MASK) ? 8'h01 : 8'h20;
                default: return 8'h01;
            endcase
        end
        if (!c[2] && !c[0])
            return 8'h40;
        if (c[2:0] == 3'h1)
            return 8'h80;
        return 8'h01;
    endfunction

    task automatic check_all();
        logic [7:0] m;
        logic a;
        logic ce;
        `CHK({utopia_l2, utopia_l3, pkt_l2, pkt_l3}, 4'h8 >> bus_sel, "bus type")
        for (int p = 0; p < 4; p++)
        begin
            m = exp_mode(mode_code[6*p +: 6], e3[p]);
            a = (m == 8'h10 || m == 8'h20) ? 1'b1 : (!bus_sel[1] ? 1'b1 : cps[p]);
            ce = e3[p] && mode_code[6*p+5] == 1'b0 && mode_code[6*p +: 3] == 3'h5
                && mode_code[6*p +: 6] != fmd_pkg::MODE_E3_G751_MASK;
            `CHK(mode_onehot[8*p +: 8], m, "mode select")
            if (m != 8'h01)
                `CHK(atm_cells[p], a, "cell processing")
            `CHK(framer_enable[p], |(m & 8'h3E), "framer enable")
            `CHK(line_unit_enable[p], |(m & 8'h5E), "line unit enable")
            `CHK(datapath_reset[p], m == 8'h01, "datapath reset")
            `CHK(config_error[p], ce, "E3 mask code")
            `CHK(effective_line_mode[3*p +: 3], (m == 8'h20 || m == 8'h80) ?
                fmd_pkg::LINE_UNIPOLAR : line_code[3*p +: 3], "line mode")
        end
    endtask

    // Inputs change just after an edge; the next edge takes them and outputs settle by negedge.
    task automatic apply(input logic [23:0] f, input logic [1:0] s, input logic [3:0] c,
        input logic [3:0] e);
        @(posedge clk);
        mode_code <= f;
        bus_sel <= s;
        cps <= c;
        e3 <= e;
        line_code <= 12'($urandom);
        @(posedge clk);
        @(negedge clk);
        check_all();
    endtask

    task automatic check_reset();
        @(negedge clk);
        `CHK(mode_onehot, {4{8'h01}}, "reset mode")
        `CHK(datapath_reset, 4'hF, "reset datapath")
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // About 1140 cycles are needed; the limit leaves ample margin.
    initial
    begin
        #200us;
        n_mismatch++;
        complete_run();
    end

    initial
    begin
        arst_n = 1'b0;
        bus_sel = 2'h0;
        mode_code = 24'h000000;
        cps = 4'h0;
        e3 = 4'h0;
        line_code = 12'h000;
        seed_ret = $urandom(58456);
        repeat (20) @(posedge clk);
        check_reset();
        @(posedge clk);
        arst_n <= 1'b1;
        // Every code on every port, each port a different code, both line types.
        for (int c = 0; c < 64; c++)
        begin
            for (int s = 0; s < 4; s++)
            begin
                apply({6'(c + 51), 6'(c + 34), 6'(c + 17), 6'(c)}, 2'(s), 4'($urandom),
                    {4{s[0]}});
            end
        end
        for (int i = 0; i < 300; i++)
            // One six-bit code can never name a fractional and a mask mode at once.
            apply(24'($urandom), 2'($urandom), 4'($urandom), 4'($urandom));
        @(posedge clk);
        arst_n <= 1'b0;
        check_reset();
        @(posedge clk);
        arst_n <= 1'b1;
        apply({6'h15, 6'h05, 6'h21, 6'h06}, 2'h3, 4'h0, 4'hF);
        complete_run();
    end
endmodule
`default_nettype wire
